// *** src/rzwp_pkg.sv ***
// Shared constants for the zone write-protect host controller.
package rzwp_pkg;
  // ==========================================================
  // Clock and single-wire bit timing (high speed mode)
  // ==========================================================
  localparam int CLK_MHZ = 40; // System clock rate in MHz.
  localparam int LOW0_NS = 8000; // Low time that sends a logic 0.
  localparam int LOW1_NS = 1500; // Low time that sends a logic 1.
  localparam int RD_NS = 1000; // Low time that opens a read bit frame.
  localparam int MRS_NS = 1750; // Strobe point for sampling a read bit.
  localparam int BIT_NS = 25000; // Whole bit frame, a longest time.
  localparam int HTSS_NS = 150000; // Line high time for start and stop.
  localparam int WRITE_ABORT_LOW_TIME_NS = 150000; // Discharge low time.
  localparam int WR_MS = 5; // Longest self-timed write cycle.
  // Least times round up, longest times round down.
  localparam int LOW0_CYC = (LOW0_NS * CLK_MHZ + 999) / 1000;
  localparam int LOW1_CYC = (LOW1_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_CYC = (RD_NS * CLK_MHZ + 999) / 1000;
  localparam int MRS_CYC = (MRS_NS * CLK_MHZ + 999) / 1000;
  localparam int BIT_CYC = (BIT_NS * CLK_MHZ) / 1000;
  localparam int HTSS_CYC = (HTSS_NS * CLK_MHZ + 999) / 1000;
  localparam int DSCHG_CYC = (WRITE_ABORT_LOW_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_CYC = WR_MS * CLK_MHZ * 1000;
  localparam int CNT_W = 18; // Wide enough for the write-cycle wait.
  // ==========================================================
  // Device opcodes and fixed bytes
  // ==========================================================
  localparam logic [3:0] OPC_ZONE = 4'h7; // Zone lock register access.
  localparam logic [3:0] OPC_FREEZE = 4'h1; // Freeze of the lock registers.
  localparam logic [3:0] OPC_ARRAY = 4'hA; // Array write.
  localparam logic [7:0] LOCK_DATA = 8'hFF; // Data byte that sets a lock.
  localparam logic [7:0] FREEZE_ADDR = 8'h55; // Freeze address byte.
  localparam logic [7:0] FREEZE_DATA = 8'hAA; // Freeze data byte.
  localparam logic [7:0] ZONE0_LOCK_ADDR = 8'h01; // zone0_write_lock.
  localparam logic [7:0] ZONE1_LOCK_ADDR = 8'h02; // zone1_write_lock.
  localparam logic [7:0] ZONE2_LOCK_ADDR = 8'h04; // zone2_write_lock.
  localparam logic [7:0] ZONE3_LOCK_ADDR = 8'h08; // zone3_write_lock.
  localparam logic [7:0] LOCKED_BYTE = 8'hFF; // Status byte of a locked zone.
  localparam logic LOCK_RESET = 1'h0; // Lock bits leave the factory clear.
  // ==========================================================
  // Controller registers on AXI4-Lite
  // ==========================================================
  localparam logic [3:0] REG_CTRL = 4'h0; // Command code; a write starts it.
  localparam logic [3:0] REG_ARG = 4'h4; // Address, data and slave address.
  localparam logic [3:0] REG_STATUS = 4'h8; // Busy, done, nack, read byte.
  localparam int ARG_ADDR_LSB = 0; // Zone register or word address.
  localparam int ARG_DATA_LSB = 8; // Array write data byte.
  localparam int ARG_SLV_LSB = 16; // Three-bit slave address.
  localparam int ST_BUSY = 0; // Status: command running.
  localparam int ST_DONE = 1; // Status: command finished.
  localparam int ST_NACK = 2; // Status: device refused a byte.
  localparam int ST_LOCKED = 3; // Status: last lock read saw a locked zone.
  localparam int ST_RD_LSB = 8; // Status: last byte read.
  localparam logic [1:0] RESP_OKAY = 2'h0; // AXI okay response.
  localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI answer to unmapped offsets.
  // ==========================================================
  // Commands, line operations and sequence actions
  // ==========================================================
  typedef enum logic [2:0] {
    CMD_LOCK_READ = 3'h0, CMD_LOCK_SET = 3'h1, CMD_FREEZE = 3'h2,
    CMD_ARRAY_WR = 3'h3, CMD_DISCHARGE = 3'h4
  } rzwp_cmd_type;
  typedef enum logic [2:0] {
    OP_TX = 3'h0, OP_RX = 3'h1, OP_HIGH = 3'h2, OP_DSCHG = 3'h3, OP_WAIT = 3'h4
  } rzwp_op_type;
  typedef enum logic [2:0] {
    ACT_START = 3'h0, ACT_TX = 3'h1, ACT_RX = 3'h2, ACT_STOP = 3'h3,
    ACT_WR = 3'h4, ACT_DSCHG = 3'h5, ACT_END = 3'h6
  } rzwp_act_type;
endpackage

// *** src/rzwp_bit_if.sv ***
// Bit-frame request and answer link between sequencer and line engine.
`timescale 1ns/1ps
interface rzwp_bit_if;
  logic req; // One-cycle pulse: start one line operation.
  rzwp_pkg::rzwp_op_type op; // Operation to perform.
  logic tx_bit; // Bit value for a transmit frame.
  logic done; // One-cycle pulse: operation finished.
  logic rx_bit; // Sampled line level of the last frame.
  modport seq (output req, output op, output tx_bit, input done, input rx_bit);
  modport eng (input req, input op, input tx_bit, output done, output rx_bit);
endinterface

// *** src/rzwp_bit_engine.sv ***
// Line engine: times one bit frame, start/stop gap, discharge or wait.
`timescale 1ns/1ps
module rzwp_bit_engine #(
  parameter int HTSS_CYC = rzwp_pkg::HTSS_CYC,
  parameter int DSCHG_CYC = rzwp_pkg::DSCHG_CYC,
  parameter int WR_CYC = rzwp_pkg::WR_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  rzwp_bit_if.eng bi,
  input wire logic sio_in,
  output logic sio_oe
);
  // ==========================================================
  // Frame timing
  // ==========================================================
  logic busy_r; // Operation in progress.
  logic [rzwp_pkg::CNT_W-1:0] cnt_r; // Cycles elapsed in this operation.
  logic [rzwp_pkg::CNT_W-1:0] low_r; // Cycles the line is held low.
  logic [rzwp_pkg::CNT_W-1:0] total_r; // Cycles of the whole operation.
  logic [rzwp_pkg::CNT_W-1:0] low_nxt; // Low length of a new request.
  logic [rzwp_pkg::CNT_W-1:0] total_nxt; // Total length of a new request.
  logic [rzwp_pkg::CNT_W-1:0] cnt_nxt; // Counter after this cycle.
  logic rx_bit_r; // Sampled bit.
  logic done_r; // Completion pulse.

  // Lengths for the requested operation.
  always_comb begin
    low_nxt = '0;
    total_nxt = rzwp_pkg::CNT_W'(rzwp_pkg::BIT_CYC);
    unique case (bi.op)
      rzwp_pkg::OP_TX: begin
        low_nxt = bi.tx_bit ? rzwp_pkg::CNT_W'(rzwp_pkg::LOW1_CYC) : rzwp_pkg::CNT_W'(rzwp_pkg::LOW0_CYC);
      end
      rzwp_pkg::OP_RX: begin
        low_nxt = rzwp_pkg::CNT_W'(rzwp_pkg::RD_CYC);
      end
      rzwp_pkg::OP_HIGH: begin
        total_nxt = rzwp_pkg::CNT_W'(HTSS_CYC);
      end
      rzwp_pkg::OP_DSCHG: begin
        // Held low the whole discharge time, then a recovery frame released.
        low_nxt = rzwp_pkg::CNT_W'(DSCHG_CYC);
        total_nxt = rzwp_pkg::CNT_W'(DSCHG_CYC + rzwp_pkg::BIT_CYC);
      end
      rzwp_pkg::OP_WAIT: begin
        // The line is left to the pull-up for the whole write cycle.
        total_nxt = rzwp_pkg::CNT_W'(WR_CYC);
      end
      default: begin
        total_nxt = rzwp_pkg::CNT_W'(rzwp_pkg::BIT_CYC);
      end
    endcase
  end

  assign cnt_nxt = cnt_r + rzwp_pkg::CNT_W'(1);

  // Counter and line drive; requests are only taken while idle.
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      low_r <= '0;
      total_r <= '0;
      sio_oe <= 1'b0;
      done_r <= 1'b0;
    end else if (ce) begin
      done_r <= 1'b0;
      if (!busy_r) begin
        if (bi.req) begin
          busy_r <= 1'b1;
          cnt_r <= '0;
          low_r <= low_nxt;
          total_r <= total_nxt;
          sio_oe <= (low_nxt != '0);
        end
      end else begin
        cnt_r <= cnt_nxt;
        sio_oe <= (cnt_nxt < low_r);
        if (cnt_nxt == total_r) begin
          busy_r <= 1'b0;
          sio_oe <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  // Read strobe: the line is sampled once, past the pull-up rise.
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_bit_r <= 1'b1;
    end else if (ce && busy_r && cnt_r == rzwp_pkg::CNT_W'(rzwp_pkg::MRS_CYC)) begin
      rx_bit_r <= sio_in;
    end
  end

  assign bi.done = done_r;
  assign bi.rx_bit = rx_bit_r;
endmodule // rzwp_bit_engine

// *** src/rzwp_host.sv ***
// Host controller that locks, reads and freezes zone write protection.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module rzwp_host #(
  parameter int HTSS_CYC = rzwp_pkg::HTSS_CYC,
  parameter int DSCHG_CYC = rzwp_pkg::DSCHG_CYC,
  parameter int WR_CYC = rzwp_pkg::WR_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sio_in,
  output logic sio_out,
  output logic sio_oe
);
  // ==========================================================
  // Sequence program
  // ==========================================================
  // Action taken at each step of a command.
  function automatic rzwp_pkg::rzwp_act_type step_act(rzwp_pkg::rzwp_cmd_type c, logic [2:0] i);
    rzwp_pkg::rzwp_act_type a;
    a = rzwp_pkg::ACT_END;
    if (c == rzwp_pkg::CMD_DISCHARGE) begin
      a = (i == 3'h0) ? rzwp_pkg::ACT_DSCHG : rzwp_pkg::ACT_END;
    end else if (c == rzwp_pkg::CMD_LOCK_READ) begin
      // Dummy write, repeated start, then the status byte.
      unique case (i)
        3'h0, 3'h3: a = rzwp_pkg::ACT_START;
        3'h1, 3'h2, 3'h4: a = rzwp_pkg::ACT_TX;
        3'h5: a = rzwp_pkg::ACT_RX;
        3'h6: a = rzwp_pkg::ACT_STOP;
        default: a = rzwp_pkg::ACT_END;
      endcase
    end else begin
      unique case (i)
        3'h0: a = rzwp_pkg::ACT_START;
        3'h1, 3'h2, 3'h3: a = rzwp_pkg::ACT_TX;
        3'h4: a = rzwp_pkg::ACT_STOP;
        3'h5: a = rzwp_pkg::ACT_WR;
        default: a = rzwp_pkg::ACT_END;
      endcase
    end
    return a;
  endfunction

  // Byte sent at a transmit step.
  function automatic logic [7:0] tx_byte(rzwp_pkg::rzwp_cmd_type c, logic [2:0] i, logic [23:0] arg);
    logic [3:0] opc;
    logic [7:0] b;
    opc = (c == rzwp_pkg::CMD_FREEZE) ? rzwp_pkg::OPC_FREEZE
        : (c == rzwp_pkg::CMD_ARRAY_WR) ? rzwp_pkg::OPC_ARRAY : rzwp_pkg::OPC_ZONE;
    b = {opc, arg[rzwp_pkg::ARG_SLV_LSB +: 3], 1'b0};
    if (i == 3'h4) begin
      b = {opc, arg[rzwp_pkg::ARG_SLV_LSB +: 3], 1'b1};
    end else if (i == 3'h2) begin
      b = (c == rzwp_pkg::CMD_FREEZE) ? rzwp_pkg::FREEZE_ADDR : arg[rzwp_pkg::ARG_ADDR_LSB +: 8];
    end else if (i == 3'h3) begin
      b = (c == rzwp_pkg::CMD_FREEZE) ? rzwp_pkg::FREEZE_DATA
        : (c == rzwp_pkg::CMD_LOCK_SET) ? rzwp_pkg::LOCK_DATA
        : arg[rzwp_pkg::ARG_DATA_LSB +: 8];
    end
    return b;
  endfunction

  // ==========================================================
  // Register state and sequencer state
  // ==========================================================
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000, SQ_STEP = 3'b001, SQ_BIT = 3'b011, SQ_ACK = 3'b010, SQ_DONE = 3'b110
  } rzwp_sq_type;
  rzwp_sq_type sq_r; // Sequencer state.
  rzwp_pkg::rzwp_cmd_type cmd_r; // Command being run.
  rzwp_pkg::rzwp_act_type act_r; // Action of the current step.
  logic [23:0] arg_r; // Argument register.
  logic [2:0] step_r; // Step index.
  logic [3:0] bits_r; // Bits left in the current byte.
  logic [7:0] shift_r; // Byte shifter, MSB first.
  logic [7:0] rd_r; // Last byte read from the device.
  logic done_r; // Sticky done flag.
  logic nack_r; // Device refused a byte.
  logic abort_r; // Refused byte: only the stop remains.
  logic start_r; // Command request from software.
  logic aw_got_r; // Write address captured.
  logic w_got_r; // Write data captured.
  logic [3:0] awaddr_r; // Captured write address.
  logic [31:0] wdata_r; // Captured write data.
  logic [3:0] wstrb_r; // Strobes kept with the data, since wstrb only counts beside wvalid.
  logic req_r; // Request to the line engine.
  rzwp_pkg::rzwp_op_type op_r; // Operation to the line engine.
  logic txb_r; // Bit to the line engine.
  rzwp_pkg::rzwp_act_type act_nxt; // Action at the current step.
  logic busy; // Command running.
  logic [31:0] status; // Status word.
  rzwp_bit_if bi ();

  assign busy = (sq_r != SQ_IDLE);
  assign act_nxt = abort_r ? rzwp_pkg::ACT_STOP : step_act(cmd_r, step_r);
  // A locked zone answers FFh; anything else counts as unlocked.
  assign status = {16'h0, rd_r, 4'h0, (rd_r == rzwp_pkg::LOCKED_BYTE), nack_r, done_r, busy};

  // ==========================================================
  // AXI4-Lite write channel
  // ==========================================================
  // Address and data are taken in either order; the answer follows both.
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rzwp_pkg::RESP_OKAY;
      arg_r <= 24'h0;
      start_r <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_got_r && !s_axi_wready && !s_axi_bvalid;
      start_r <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_got_r && w_got_r) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= rzwp_pkg::RESP_OKAY;
        if (awaddr_r == rzwp_pkg::REG_ARG) begin
          // Argument writes are dropped, not applied later, while a command uses it.
          if (!busy && wstrb_r[0]) arg_r[7:0] <= wdata_r[7:0];
          if (!busy && wstrb_r[1]) arg_r[15:8] <= wdata_r[15:8];
          if (!busy && wstrb_r[2]) arg_r[23:16] <= wdata_r[23:16];
        end else if (awaddr_r == rzwp_pkg::REG_CTRL) begin
          start_r <= wstrb_r[0];
        end else if (awaddr_r != rzwp_pkg::REG_STATUS) begin
          s_axi_bresp <= rzwp_pkg::RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  // ==========================================================
  // One read at a time; unmapped offsets read zero with SLVERR.
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= rzwp_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rzwp_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          rzwp_pkg::REG_CTRL: s_axi_rdata <= {29'h0, cmd_r};
          rzwp_pkg::REG_ARG: s_axi_rdata <= {8'h0, arg_r};
          rzwp_pkg::REG_STATUS: s_axi_rdata <= status;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= rzwp_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Command sequencer
  // ==========================================================
  // Walks the step program, one line operation at a time; a start
  // request while busy is dropped so a running write cycle is never cut.
  always_ff @(posedge clk) begin
    if (reset) begin
      sq_r <= SQ_IDLE;
      cmd_r <= rzwp_pkg::CMD_LOCK_READ;
      act_r <= rzwp_pkg::ACT_END;
      step_r <= 3'h0;
      bits_r <= 4'h0;
      shift_r <= 8'h0;
      rd_r <= 8'h0;
      done_r <= 1'b0;
      nack_r <= 1'b0;
      abort_r <= 1'b0;
      req_r <= 1'b0;
      op_r <= rzwp_pkg::OP_HIGH;
      txb_r <= 1'b1;
    end else if (ce) begin
      req_r <= 1'b0;
      unique case (sq_r)
        SQ_IDLE: begin
          if (start_r) begin
            cmd_r <= rzwp_pkg::rzwp_cmd_type'(wdata_r[2:0]);
            step_r <= 3'h0;
            done_r <= 1'b0;
            nack_r <= 1'b0;
            abort_r <= 1'b0;
            sq_r <= SQ_STEP;
          end
        end
        SQ_STEP: begin
          act_r <= act_nxt;
          req_r <= (act_nxt != rzwp_pkg::ACT_END);
          sq_r <= (act_nxt == rzwp_pkg::ACT_END) ? SQ_DONE : SQ_BIT;
          bits_r <= 4'h8;
          shift_r <= tx_byte(cmd_r, step_r, arg_r);
          txb_r <= tx_byte(cmd_r, step_r, arg_r) >> 7 != 8'h0;
          unique case (act_nxt)
            rzwp_pkg::ACT_TX: op_r <= rzwp_pkg::OP_TX;
            rzwp_pkg::ACT_RX: op_r <= rzwp_pkg::OP_RX;
            rzwp_pkg::ACT_DSCHG: op_r <= rzwp_pkg::OP_DSCHG;
            rzwp_pkg::ACT_WR: op_r <= rzwp_pkg::OP_WAIT;
            default: op_r <= rzwp_pkg::OP_HIGH;
          endcase
        end
        SQ_BIT: begin
          if (bi.done) begin
            if (act_r == rzwp_pkg::ACT_TX || act_r == rzwp_pkg::ACT_RX) begin
              shift_r <= {shift_r[6:0], bi.rx_bit};
              bits_r <= bits_r - 4'h1;
              req_r <= 1'b1;
              if (bits_r == 4'h1) begin
                // Byte done: read the device's answer, or send our NACK.
                op_r <= (act_r == rzwp_pkg::ACT_TX) ? rzwp_pkg::OP_RX : rzwp_pkg::OP_TX;
                txb_r <= 1'b1;
                if (act_r == rzwp_pkg::ACT_RX) rd_r <= {shift_r[6:0], bi.rx_bit};
                sq_r <= SQ_ACK;
              end else begin
                txb_r <= shift_r[6];
              end
            end else begin
              step_r <= step_r + 3'h1;
              sq_r <= abort_r ? SQ_DONE : SQ_STEP;
            end
          end
        end
        SQ_ACK: begin
          if (bi.done) begin
            // A refused byte ends the command with a stop and no write wait.
            if (act_r == rzwp_pkg::ACT_TX && bi.rx_bit) begin
              nack_r <= 1'b1;
              abort_r <= 1'b1;
            end
            step_r <= step_r + 3'h1;
            sq_r <= SQ_STEP;
          end
        end
        SQ_DONE: begin
          done_r <= 1'b1;
          sq_r <= SQ_IDLE;
        end
        default: sq_r <= SQ_IDLE;
      endcase
    end
  end

  assign bi.req = req_r;
  assign bi.op = op_r;
  assign bi.tx_bit = txb_r;

  // The pin only ever pulls low; release is left to the pull-up.
  always_ff @(posedge clk) begin
    if (reset) begin
      sio_out <= 1'b0;
    end else if (ce) begin
      sio_out <= 1'b0;
    end
  end

  rzwp_bit_engine #(
    .HTSS_CYC(HTSS_CYC),
    .DSCHG_CYC(DSCHG_CYC),
    .WR_CYC(WR_CYC)
  ) u_engine (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .bi(bi),
    .sio_in(sio_in),
    .sio_oe(sio_oe)
  );
endmodule // rzwp_host

// *** dv/rzwp_host_chk.sv ***
// Port checker for the zone write-protect host.
`timescale 1ns/1ps
module rzwp_host_chk #(
  parameter int HTSS_CYC = 6000,
  parameter int DSCHG_CYC = 6000,
  parameter int WR_CYC = 200000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic sio_out,
  input wire logic sio_oe
);
  // ========
  // Run lengths of pull and release.
  // ========
  int low_c; // Cycles the line is pulled.
  int rel_c; // Cycles the line is free.
  always_ff @(posedge clk) begin
    low_c <= (reset || !sio_oe) ? 0 : low_c + 1;
    rel_c <= (reset || sio_oe) ? 0 : rel_c + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  bresp_delay_a: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer mistimed");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rdata_delay_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  unmapped_read_a: assert property (rd_taken ##0 s_axi_araddr == 4'hC |=> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  ready_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  low_width_a: assert property ($fell(sio_oe) |-> low_c inside {[40:80], [240:640]} || low_c >= DSCHG_CYC)
    else $error("bad low pulse width");
  line_gap_a: assert property ($rose(sio_oe) |-> rel_c <= 963 || rel_c >= HTSS_CYC)
    else $error("line pulled inside a gap");
  open_drain_a: assert property (!sio_out)
    else $error("line driven high");
endmodule // rzwp_host_chk
bind rzwp_host rzwp_host_chk #(.HTSS_CYC(HTSS_CYC), .DSCHG_CYC(DSCHG_CYC), .WR_CYC(WR_CYC)) u_chk (
  .clk(clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .sio_out(sio_out), .sio_oe(sio_oe));

// *** dv/rzwp_dev_model.sv ***
// Behavioural model of the zone-locked memory device.
`timescale 1ns/1ps
module rzwp_dev_model (
  input wire logic clk,
  input wire logic host_oe,
  output logic dev_pd
);
  // ========
  // State; none of it follows the host reset.
  // ========
  logic [3:0] lock_r = 4'h0;
  logic [7:0] sh_r = 8'h00, za_r = 8'h00;
  logic [3:0] op_r = 4'h0, fr_r = 4'h0;
  logic [1:0] bi_r = 2'h0, zi;
  logic frz_r = 1'b0, tx_r = 1'b0, nak_r = 1'b0, set_r = 1'b0, fz_r = 1'b0, oe_d = 1'b0, ack;
  int lo_r = 0, hi_r = 0, pd_r = 0, busy_r = 0;
  assign dev_pd = pd_r != 0;
  assign zi = za_r[3] ? 2'h3 : za_r[2] ? 2'h2 : {1'b0, za_r[1]};
  // Whether the byte just shifted in earns an acknowledge.
  always_comb begin
    ack = busy_r == 0 && !nak_r;
    case (bi_r)
      2'h0: ack = ack && (sh_r[7:4] inside {4'h7, 4'hA} || (sh_r[7:4] == 4'h1 && !frz_r));
      2'h1: ack = ack && (op_r == 4'h1 ? sh_r == 8'h55 : op_r == 4'hA || $onehot(sh_r[3:0]));
      default: ack = ack && (op_r == 4'h7 ? sh_r == 8'hFF && !frz_r
        : op_r == 4'h1 ? sh_r == 8'hAA : !lock_r[za_r[6:5]]);
    endcase
  end
  // Low length gives the bit; a long free gap is a start or a stop.
  always_ff @(posedge clk) begin
    oe_d <= host_oe;
    lo_r <= host_oe ? lo_r + 1 : 0;
    hi_r <= (host_oe || dev_pd) ? 0 : hi_r + 1;
    pd_r <= (pd_r != 0) ? pd_r - 1 : 0;
    busy_r <= (busy_r != 0) ? busy_r - 1 : 0;
    if (hi_r == 1200) begin
      bi_r <= 2'h0;
      fr_r <= 4'h0;
      tx_r <= 1'b0;
      nak_r <= 1'b0;
      set_r <= 1'b0;
      fz_r <= 1'b0;
      if (set_r) lock_r[zi] <= 1'b1;
      if (set_r || fz_r) busy_r <= 150;
      if (fz_r) frz_r <= 1'b1;
    end
    // Any frame after the data byte cancels a pending write.
    if (host_oe && !oe_d) begin
      set_r <= 1'b0;
      fz_r <= 1'b0;
      if (tx_r ? fr_r < 4'h8 && !lock_r[zi] : fr_r == 4'h8 && ack) pd_r <= 200;
    end
    if (!host_oe && oe_d) begin
      fr_r <= (fr_r == 4'h8) ? 4'h0 : fr_r + 4'h1;
      if (!tx_r && fr_r != 4'h8) sh_r <= {sh_r[6:0], lo_r < 190};
      if (!tx_r && fr_r == 4'h8) begin
        bi_r <= bi_r + 2'h1;
        nak_r <= !ack;
        if (bi_r == 2'h0) op_r <= sh_r[7:4];
        if (bi_r == 2'h0) tx_r <= ack && sh_r[0];
        if (bi_r == 2'h1) za_r <= sh_r;
        set_r <= bi_r == 2'h2 && ack && op_r == 4'h7;
        fz_r <= bi_r == 2'h2 && ack && op_r == 4'h1;
      end
    end
  end
endmodule // rzwp_dev_model

// *** dv/testbench.sv ***
// Self-checking bench for the zone write-protect host.
`timescale 1ns/1ps
module testbench;
  typedef struct {
    rzwp_pkg::rzwp_cmd_type cmd;
    logic [31:0] arg;
    logic nack;
  } rzwp_row_type;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, st;
  logic awready, wready, bvalid, arready, rvalid, sio_oe, dev_pd;
  logic [1:0] bresp, rresp, r;
  int failures = 0, num_checks = 0, run_c = 0, max_c = 0;
  rzwp_row_type rows [3] = '{'{rzwp_pkg::CMD_LOCK_SET, 32'h4, 1'b0}, '{rzwp_pkg::CMD_LOCK_READ, 32'h4, 1'b0},
    '{rzwp_pkg::CMD_ARRAY_WR, 32'h5A45, 1'b1}};
  rzwp_host #(.HTSS_CYC(1250), .DSCHG_CYC(700), .WR_CYC(200)) u_rzwp_host (
    .clk(clk), .reset(reset), .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sio_in(!(sio_oe || dev_pd)), .sio_out(), .sio_oe(sio_oe));
  rzwp_dev_model u_rzwp_dev_model (.clk(clk), .host_oe(sio_oe), .dev_pd(dev_pd));
  initial forever #12.5 clk = ~clk;
  // Longest host pull, for the discharge check.
  always @(posedge clk) begin
    run_c <= sio_oe ? run_c + 1 : 0;
    max_c <= (run_c > max_c) ? run_c : max_c;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
    end while (bvalid !== 1'b1 || bready !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    st = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Starts one command and polls until it reports done.
  task automatic run_cmd(input rzwp_pkg::rzwp_cmd_type c, input logic [31:0] a);
    axi_wr(rzwp_pkg::REG_ARG, a);
    axi_wr(rzwp_pkg::REG_CTRL, {29'h0, c});
    do begin
      axi_rd(rzwp_pkg::REG_STATUS);
    end while (st[rzwp_pkg::ST_DONE] !== 1'b1);
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Each lock or array command run costs tens of thousands of cycles; the discharge costs under two thousand.
  initial begin
    repeat (110000) @(posedge clk);
    failures++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    chk({28'h0, u_rzwp_dev_model.lock_r}, 32'h0, "lock reset");
    foreach (rows[i]) begin
      run_cmd(rows[i].cmd, rows[i].arg);
      chk({31'h0, st[rzwp_pkg::ST_NACK]}, {31'h0, rows[i].nack}, "nack");
      if (i == 1) chk({23'h0, st[rzwp_pkg::ST_RD_LSB +: 8], st[3]}, 32'h1FF, "lock byte");
    end
    chk({28'h0, u_rzwp_dev_model.lock_r}, 32'h4, "zone locks");
    axi_rd(4'hC);
    chk({30'h0, r}, 32'h2, "unmapped read response");
    chk(st, 32'h0, "unmapped read data");
    axi_wr(4'hC, 32'h0);
    chk({30'h0, r}, 32'h2, "unmapped write");
    run_cmd(rzwp_pkg::CMD_DISCHARGE, 32'h0);
    chk({31'h0, max_c >= 700}, 32'h1, "discharge");
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    axi_rd(rzwp_pkg::REG_STATUS);
    chk({28'h0, st[3:0]}, 32'h0, "status reset");
    chk({28'h0, u_rzwp_dev_model.lock_r}, 32'h4, "locks kept");
    close_out();
  end
endmodule // testbench
